// File: rtl/tws_crc8.sv
/*
 * one-byte step of the smbus packet-check crc-8, msb first.
 * purely combinational; the caller holds the running value.
 */
module tws_crc8
  import tws_pkg::*;
(
  input wire logic [7:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [7:0] crc_o
);
  // ==========================================================
  // bitwise division by x^8+x^2+x+1
  always_comb begin
    logic [7:0] c;
    c = crc_i ^ data_i;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    crc_o = c;
  end

endmodule : tws_crc8

// File: rtl/tws_pkg.sv
/*
 * shared constants for the two-wire slave: register map, field positions,
 * reserved bus addresses and the link-side state encoding.
 * assumes a 32-bit wishbone register bus with word-aligned registers.
 */
package tws_pkg;

  // ==========================================================
  // register map
  localparam int unsigned AW = 5;
  localparam logic [AW-1:0] OFS_CTRL = 5'h00;
  localparam logic [AW-1:0] OFS_STAT = 5'h04;
  localparam logic [AW-1:0] OFS_CNT = 5'h08;
  localparam logic [AW-1:0] OFS_DATA = 5'h0c;
  localparam logic [AW-1:0] OFS_REL = 5'h10;

  // ==========================================================
  // slave_control fields
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h07ff_ff01;
  localparam int unsigned B_EN = 0;
  localparam int unsigned B_ALERT = 8;
  localparam int unsigned B_DEFAULT_ADDRESS_ACCEPT = 9;
  localparam int unsigned B_HOST_HEADER_ACCEPT = 10;
  localparam int unsigned B_PACKET_CHECK_ENABLE = 11;
  localparam int unsigned B_ACK = 12;
  localparam int unsigned B_CUP = 13;
  localparam int unsigned B_STRETCH_ON_ADDRESS_MATCH = 14;
  localparam int unsigned B_STRETCH_ON_DATA_RECEIVE = 15;
  localparam int unsigned ADR_LO = 16;
  localparam int unsigned ADR_HI = 25;
  localparam int unsigned B_TEN = 26;

  // status and release fields
  localparam int unsigned S_STRETCH = 0;
  localparam int unsigned S_PECERR = 1;
  localparam int unsigned S_READ = 2;
  localparam int unsigned S_ALERT = 3;
  localparam int unsigned R_GO = 0;
  localparam int unsigned R_PEC = 1;

  // ==========================================================
  // bus-level constants
  localparam logic [6:0] HOST_HDR_ADDR = 7'h08;
  localparam logic [6:0] DEFAULT_ADDR = 7'h61;
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
  localparam logic [4:0] TEN_HDR = 5'h1e;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // ==========================================================
  // link state machine, gray steps along the usual path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_A = 4'h3,
    ST_RX = 4'h2,
    ST_ACK_D = 4'h6,
    ST_STRETCH = 4'h7,
    ST_TX = 4'h5,
    ST_TACK = 4'h4,
    ST_ADDR2 = 4'hc
  } tws_state_e;

endpackage : tws_pkg

// File: rtl/tws_slave.sv
/*
 * two-wire (i2c/smbus) slave with a wishbone register file.
 * assumes an external bus master on scl/sda, pins pulled up outside, and a
 * link clock much faster than scl that oversamples the bus.
 */
module tws_slave
  import tws_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tws_pkg::AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic link_clk_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic alert_i,
  output logic alert_o,
  output logic alert_oe_n_o
);
  import tws_pkg::*;

  // ==========================================================
  // system domain: bus slave and registers
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] ctrl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_data_q;
  logic pec_req_q;
  logic rel_tgl_q;
  logic pecerr_q;
  logic req, wr_en, cnt_wr, byte_evt, pec_evt;
  logic [31:0] rdata;
  logic s_byte, s_pec, s_stretch, s_read, s_alert;
  logic s_byte_p_q, s_pec_p_q;
  logic [3:0] ls;
  logic [7:0] rx_byte_q;

  assign req = ce_i & wb_cyc_i & wb_stb_i;
  // a write lands on the edge where the master sees ack
  assign wr_en = req & wb_we_i & ack_q;
  assign cnt_wr = wr_en & (wb_adr_i == OFS_CNT) & wb_sel_i[0];
  assign {s_byte, s_pec, s_stretch, s_read} = ls;
  assign byte_evt = s_byte ^ s_byte_p_q;
  assign pec_evt = s_pec ^ s_pec_p_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_comb begin
    rdata = 32'h0000_0000;
    if (wb_adr_i == OFS_CTRL) begin
      rdata = ctrl_q;
    end else if (wb_adr_i == OFS_STAT) begin
      rdata[S_STRETCH] = s_stretch;
      rdata[S_PECERR] = pecerr_q;
      rdata[S_READ] = s_read;
      rdata[S_ALERT] = s_alert;
    end else if (wb_adr_i == OFS_CNT) begin
      rdata[CNT_W-1:0] = cnt_q;
    end else if (wb_adr_i == OFS_DATA) begin
      rdata[7:0] = rx_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      if (wb_cyc_i & wb_stb_i & ~ack_q) begin
        dat_q <= rdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_en & (wb_adr_i == OFS_CTRL)) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctrl_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8] & CTRL_MASK[b*8 +: 8];
        end
      end
    end
  end

  // release write: tx byte and pec choice are held until the link sees the
  // toggle, so software writes the tx byte before releasing; the pec choice comes with the release write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data_q <= 8'h00;
      pec_req_q <= 1'b0;
      rel_tgl_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_en & (wb_adr_i == OFS_DATA) & wb_sel_i[0]) begin
        tx_data_q <= wb_dat_i[7:0];
      end
      if (wr_en & (wb_adr_i == OFS_REL) & wb_sel_i[0] & wb_dat_i[R_GO]) begin
        pec_req_q <= wb_dat_i[R_PEC] & ctrl_q[B_PACKET_CHECK_ENABLE];
        rel_tgl_q <= ~rel_tgl_q;
      end
    end
  end

  // bus write to the counter wins over a byte in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (ce_i) begin
      if (cnt_wr) begin
        cnt_q <= wb_dat_i[CNT_W-1:0];
      end else if (byte_evt & ctrl_q[B_CUP]) begin
        cnt_q <= cnt_q + CNT_W'(1);
      end else if (byte_evt) begin
        cnt_q <= cnt_q - CNT_W'(1);
      end
    end
  end

  // pec error is sticky, write one to clear; a new error wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pecerr_q <= 1'b0;
      rx_q <= 8'h00;
      s_byte_p_q <= 1'b0;
      s_pec_p_q <= 1'b0;
    end else if (ce_i) begin
      s_byte_p_q <= s_byte;
      s_pec_p_q <= s_pec;
      if (byte_evt & ~s_read) begin
        rx_q <= rx_byte_q;
      end
      if (pec_evt) begin
        pecerr_q <= 1'b1;
      end else if (wr_en & (wb_adr_i == OFS_STAT) & wb_sel_i[0]
                   & wb_dat_i[S_PECERR]) begin
        pecerr_q <= 1'b0;
      end
    end
  end

  assign alert_o = 1'b0;
  assign alert_oe_n_o = ~ctrl_q[B_ALERT];

  // ==========================================================
  // crossings
  logic lrst;
  logic [31:0] lc;
  logic l_ce, l_rel;
  logic scl_s, sda_s;
  logic byte_tgl_q, pec_tgl_q, scl_oe_n_q, sda_oe_n_q, rw_q;

  tws_sync #(.W(1)) u_rst (.clk_i(link_clk_i), .d_i(rst_i), .q_o(lrst));
  tws_sync #(.W(32)) u_ctrl (.clk_i(link_clk_i), .d_i(ctrl_q), .q_o(lc));
  tws_sync #(.W(2)) u_misc (
    .clk_i(link_clk_i),
    .d_i({ce_i, rel_tgl_q}),
    .q_o({l_ce, l_rel})
  );
  tws_sync #(.W(2)) u_pins (
    .clk_i(link_clk_i),
    .d_i({scl_i, sda_i}),
    .q_o({scl_s, sda_s})
  );
  tws_sync #(.W(4)) u_back (
    .clk_i(clk_i),
    .d_i({byte_tgl_q, pec_tgl_q, ~scl_oe_n_q, rw_q}),
    .q_o(ls)
  );
  tws_sync #(.W(1)) u_alert (.clk_i(clk_i), .d_i(alert_i), .q_o(s_alert));

  // ==========================================================
  // link domain: bit engine
  tws_state_e st_q, next_q;
  logic [3:0] bitcnt_q;
  logic [7:0] sh_q, txs_q, txb_q, tx_hold_q, crc_q, crc_nxt, crc_byte;
  logic scl_p_q, sda_p_q, rel_p_q, hdr_q, ten_hit_q, rx_any_q;
  logic scl_rise, scl_fall, start_c, stop_c, byte_end, rel_evt;
  logic m_own, m_hh, m_da, m_ara, m_ten, addr_hit;
  logic [7:0] rel_byte;

  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_c = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_c = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign byte_end = scl_fall & (bitcnt_q == BYTE_BITS);
  assign rel_evt = l_rel ^ rel_p_q;
  assign rel_byte = pec_req_q ? crc_q : tx_data_q;

  assign m_own = ~lc[B_TEN] & (sh_q[7:1] == lc[ADR_LO +: 7]);
  assign m_hh = lc[B_HOST_HEADER_ACCEPT] & (sh_q[7:1] == HOST_HDR_ADDR);
  assign m_da = lc[B_DEFAULT_ADDRESS_ACCEPT] & (sh_q[7:1] == DEFAULT_ADDR);
  assign m_ara = lc[B_ALERT] & (sh_q[7:1] == ALERT_RESP_ADDR);
  // a read header only matches after a full 10-bit write address
  assign m_ten = lc[B_TEN] & (sh_q[7:3] == TEN_HDR)
               & (sh_q[2:1] == lc[ADR_HI -: 2])
               & (~sh_q[0] | ten_hit_q);
  assign addr_hit = m_own | m_hh | m_da | m_ara | m_ten;

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      st_q <= ST_IDLE;
      next_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      sh_q <= 8'h00;
      txs_q <= 8'h00;
      txb_q <= 8'h00;
      tx_hold_q <= 8'h00;
      rx_byte_q <= 8'h00;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      rel_p_q <= 1'b0;
      rw_q <= 1'b0;
      hdr_q <= 1'b0;
      ten_hit_q <= 1'b0;
      rx_any_q <= 1'b0;
      byte_tgl_q <= 1'b0;
      pec_tgl_q <= 1'b0;
    end else if (l_ce) begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      rel_p_q <= l_rel;
      if (~lc[B_EN]) begin
        st_q <= ST_IDLE;
        scl_oe_n_q <= 1'b1;
        sda_oe_n_q <= 1'b1;
      end else if (stop_c) begin
        st_q <= ST_IDLE;
        scl_oe_n_q <= 1'b1;
        sda_oe_n_q <= 1'b1;
        // a good pec byte leaves the running crc at zero
        if (lc[B_PACKET_CHECK_ENABLE] & rx_any_q & ~rw_q & (crc_q != 8'h00)) begin
          pec_tgl_q <= ~pec_tgl_q;
        end
      end else if (start_c) begin
        st_q <= ST_ADDR;
        bitcnt_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
        if (st_q == ST_IDLE) begin
          rx_any_q <= 1'b0;
        end
      end else begin
        case (st_q)
          ST_ADDR, ST_ADDR2, ST_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_s};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (byte_end & (st_q == ST_ADDR)) begin
              if (~(m_ten & sh_q[0])) begin
                ten_hit_q <= 1'b0;
              end
              rw_q <= sh_q[0];
              hdr_q <= m_ten & ~sh_q[0];
              sda_oe_n_q <= ~addr_hit;
              st_q <= addr_hit ? ST_ACK_A : ST_IDLE;
            end else if (byte_end & (st_q == ST_ADDR2)) begin
              hdr_q <= 1'b0;
              if (sh_q == lc[ADR_LO +: 8]) begin
                ten_hit_q <= 1'b1;
                sda_oe_n_q <= 1'b0;
                st_q <= ST_ACK_A;
              end else begin
                st_q <= ST_IDLE;
              end
            end else if (byte_end) begin
              rx_byte_q <= sh_q;
              byte_tgl_q <= ~byte_tgl_q;
              rx_any_q <= 1'b1;
              if (lc[B_STRETCH_ON_DATA_RECEIVE]) begin
                scl_oe_n_q <= 1'b0;
                next_q <= ST_ACK_D;
                st_q <= ST_STRETCH;
              end else begin
                sda_oe_n_q <= lc[B_ACK];
                st_q <= ST_ACK_D;
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              sda_oe_n_q <= 1'b1;
              bitcnt_q <= 4'h0;
              if (hdr_q) begin
                st_q <= ST_ADDR2;
              end else if (lc[B_STRETCH_ON_ADDRESS_MATCH]) begin
                scl_oe_n_q <= 1'b0;
                next_q <= rw_q ? ST_TX : ST_RX;
                st_q <= ST_STRETCH;
              end else if (rw_q) begin
                txb_q <= tx_hold_q;
                txs_q <= {tx_hold_q[6:0], 1'b0};
                sda_oe_n_q <= tx_hold_q[7];
                st_q <= ST_TX;
              end else begin
                st_q <= ST_RX;
              end
            end
          end
          ST_ACK_D: begin
            if (scl_fall) begin
              sda_oe_n_q <= 1'b1;
              bitcnt_q <= 4'h0;
              st_q <= ST_RX;
            end
          end
          ST_STRETCH: begin
            // scl stays low until software releases it
            if (rel_evt) begin
              scl_oe_n_q <= 1'b1;
              st_q <= next_q;
              if (next_q == ST_ACK_D) begin
                sda_oe_n_q <= lc[B_ACK];
              end else if (next_q == ST_TX) begin
                tx_hold_q <= rel_byte;
                txb_q <= rel_byte;
                txs_q <= {rel_byte[6:0], 1'b0};
                sda_oe_n_q <= rel_byte[7];
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (byte_end) begin
              sda_oe_n_q <= 1'b1;
              byte_tgl_q <= ~byte_tgl_q;
              st_q <= ST_TACK;
            end else if (scl_fall) begin
              sda_oe_n_q <= txs_q[7];
              txs_q <= {txs_q[6:0], 1'b0};
            end
          end
          ST_TACK: begin
            if (scl_rise & sda_s) begin
              st_q <= ST_IDLE;
            end else if (scl_fall) begin
              bitcnt_q <= 4'h0;
              txb_q <= tx_hold_q;
              txs_q <= {tx_hold_q[6:0], 1'b0};
              sda_oe_n_q <= tx_hold_q[7];
              st_q <= ST_TX;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // running pec over every byte of the transfer
  assign crc_byte = (st_q == ST_TX) ? txb_q : sh_q;

  tws_crc8 u_crc (.crc_i(crc_q), .data_i(crc_byte), .crc_o(crc_nxt));

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      crc_q <= 8'h00;
    end else if (l_ce) begin
      if (start_c & (st_q == ST_IDLE)) begin
        crc_q <= 8'h00;
      end else if (byte_end & ~stop_c & ~start_c & (st_q == ST_ADDR
                   || st_q == ST_ADDR2 || st_q == ST_RX
                   || st_q == ST_TX)) begin
        crc_q <= crc_nxt;
      end
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = scl_oe_n_q;
  assign sda_oe_n_o = sda_oe_n_q;

  // ==========================================================
  // checks
  logic lgo;
  assign lgo = l_ce & lc[B_EN] & ~stop_c & ~start_c;

  a_ten_gate: assert property (@(posedge link_clk_i) disable iff (lrst)
    (st_q == ST_ADDR2) |-> lc[B_TEN])
    else $error("ten-bit second byte taken while disabled");
  a_own_match: assert property (@(posedge link_clk_i) disable iff (lrst)
    (lgo && st_q == ST_ADDR && byte_end && !lc[B_TEN]
     && sh_q[7:1] == lc[ADR_LO +: 7]) |=> (!sda_oe_n_q && st_q == ST_ACK_A))
    else $error("own seven-bit address not acknowledged");
  a_data_stretch: assert property (@(posedge link_clk_i) disable iff (lrst)
    (lgo && st_q == ST_RX && byte_end)
    |=> (scl_oe_n_q == !$past(lc[B_STRETCH_ON_DATA_RECEIVE])))
    else $error("data stretch does not follow its enable");
  a_addr_stretch: assert property (@(posedge link_clk_i) disable iff (lrst)
    (lgo && st_q == ST_ACK_A && scl_fall && !hdr_q)
    |=> (scl_oe_n_q == !$past(lc[B_STRETCH_ON_ADDRESS_MATCH])))
    else $error("address stretch does not follow its enable");
  a_count_up: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && byte_evt && !cnt_wr && ctrl_q[B_CUP])
    |=> cnt_q == CNT_W'($past(cnt_q) + CNT_W'(1)))
    else $error("byte counter failed to count up");
  a_count_down: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && byte_evt && !cnt_wr && !ctrl_q[B_CUP])
    |=> cnt_q == CNT_W'($past(cnt_q) - CNT_W'(1)))
    else $error("byte counter failed to count down");
  a_ack_level: assert property (@(posedge link_clk_i) disable iff (lrst)
    (lgo && st_q == ST_RX && byte_end && !lc[B_STRETCH_ON_DATA_RECEIVE])
    |=> (st_q == ST_ACK_D && sda_oe_n_q == $past(lc[B_ACK])))
    else $error("data acknowledge level differs from setting");
  a_pec_quiet: assert property (@(posedge link_clk_i) disable iff (lrst)
    (l_ce && stop_c && !lc[B_PACKET_CHECK_ENABLE]) |=> $stable(pec_tgl_q))
    else $error("pec error raised while checking is off");
  a_host_hdr: assert property (@(posedge link_clk_i) disable iff (lrst)
    (lgo && st_q == ST_ADDR && byte_end && lc[B_HOST_HEADER_ACCEPT]
     && sh_q[7:1] == HOST_HDR_ADDR) |=> !sda_oe_n_q)
    else $error("host header not acknowledged");
  a_default_adr: assert property (@(posedge link_clk_i) disable iff (lrst)
    (lgo && st_q == ST_ADDR && byte_end && lc[B_DEFAULT_ADDRESS_ACCEPT]
     && sh_q[7:1] == DEFAULT_ADDR) |=> !sda_oe_n_q)
    else $error("default address not acknowledged");
  a_alert_line: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_en && wb_adr_i == OFS_CTRL && wb_sel_i[1] && wb_dat_i[B_ALERT])
    |=> !alert_oe_n_o)
    else $error("alert line not pulled after enable");
  a_ten_second: assert property (@(posedge link_clk_i) disable iff (lrst)
    (lgo && st_q == ST_ADDR2 && byte_end && sh_q == lc[ADR_LO +: 8])
    |=> (ten_hit_q && st_q == ST_ACK_A))
    else $error("ten-bit low byte not acknowledged");

  c_data_rx: cover property (@(posedge link_clk_i) disable iff (lrst)
    st_q == ST_ACK_D);
  c_stretch: cover property (@(posedge link_clk_i) disable iff (lrst)
    st_q == ST_STRETCH ##1 rel_evt);
  c_tx_byte: cover property (@(posedge link_clk_i) disable iff (lrst)
    st_q == ST_TACK);

endmodule : tws_slave

// File: rtl/tws_sync.sv
/*
 * two flip-flop synchroniser for levels and toggles.
 * assumes each bit is independent or qualified by a synchronised toggle.
 */
module tws_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // ==========================================================
  // stages: the first is read only by the second
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    sync_q <= meta_q;
  end

  assign q_o = sync_q;

endmodule : tws_sync

// File: sim/tb_two_wire_slave_control.sv
/*
 * self-checking bench for the two-wire slave control block.
 * assumes tws_pkg, the slave and the i2c master model are compiled first.
 */
module tb_two_wire_slave_control;
  import tws_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [AW-1:0] wb_adr = '0;
  logic [31:0] wb_wdat = '0;
  logic [31:0] wb_rdat, ctrl, rd;
  logic wb_ack, scl_oe_n, sda_oe_n, alert_oe_n, m_scl, m_sda, a0, a1, ex;
  logic [6:0] own, a7;
  logic [9:0] own10;
  logic [7:0] d, pc;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int cnt, k;
  wire scl_w = m_scl & scl_oe_n;
  wire sda_w = m_sda & sda_oe_n;
  always #2 clk_i = ~clk_i;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  tws_slave dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link_clk_i(link_clk),
    .scl_i(scl_w), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w),
    .sda_o(), .sda_oe_n_o(sda_oe_n), .alert_i(alert_oe_n), .alert_o(),
    .alert_oe_n_o(alert_oe_n));
  tws_i2c_master m (.link_clk_i(link_clk), .scl_i(scl_w), .sda_i(sda_w),
    .scl_o(m_scl), .sda_o(m_sda));
  // ==========================================================
  // bus and check tasks
  task automatic give_verdict();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic want);
    chk({31'h0, got}, {31'h0, want});
  endtask : chk_bit
  // reference pec step, msb first, polynomial x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int j = 0; j < 8; j++) begin
      x = x[7] ? ({x[6:0], 1'b0} ^ CRC_POLY) : {x[6:0], 1'b0};
    end
    return x;
  endfunction : crc8
  task automatic wb(input logic we, input logic [AW-1:0] a,
                    input logic [31:0] dat, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    if (wb_ack !== 1'b1) n_mismatch++;
    r = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // ==========================================================
  // tests
  initial begin
    rd = $urandom(20);
    repeat (50) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (150) @(posedge clk_i);
    wb(0, OFS_CTRL, 0, rd);
    chk(rd, CTRL_RESET);
    ctrl = $urandom() & CTRL_MASK;
    wb(1, OFS_CTRL, ctrl, rd);
    wb(0, OFS_CTRL, 0, rd);
    chk(rd, ctrl);
    chk_bit(alert_oe_n, ~ctrl[B_ALERT]);
    wb(0, OFS_STAT, 0, rd);
    chk_bit(rd[S_ALERT], ~ctrl[B_ALERT]);
    wb(0, 5'h14, 0, rd);
    chk(rd, 32'h0);
    $display("done: registers");
    for (int i = 0; i < 10; i++) begin
      own = 7'h10 + 7'($urandom_range(63));
      ctrl = 32'h1 | (32'($urandom_range(7)) << B_ALERT) | (32'(own) << ADR_LO);
      a7 = (i % 5 == 0) ? own : (i % 5 == 1) ? own ^ 7'h1 :
           (i % 5 == 2) ? DEFAULT_ADDR : (i % 5 == 3) ? HOST_HDR_ADDR :
           ALERT_RESP_ADDR;
      ex = !(a7 == own || (a7 == DEFAULT_ADDR && ctrl[B_DEFAULT_ADDRESS_ACCEPT]) ||
             (a7 == HOST_HDR_ADDR && ctrl[B_HOST_HEADER_ACCEPT]) ||
             (a7 == ALERT_RESP_ADDR && ctrl[B_ALERT]));
      wb(1, OFS_CTRL, ctrl, rd);
      m.start();
      m.send({a7, 1'b0}, a0);
      m.stop();
      chk_bit(a0, ex);
    end
    $display("done: address match");
    for (int i = 0; i < 2; i++) begin
      cnt = $urandom_range(255);
      d = 8'($urandom);
      ctrl = 32'h1 | (32'(own) << ADR_LO) | (32'(i) << B_ACK) |
             (32'(1 - i) << B_CUP);
      wb(1, OFS_CTRL, ctrl, rd);
      wb(1, OFS_CNT, 32'(cnt), rd);
      m.start();
      m.send({own, 1'b0}, a0);
      m.send(8'($urandom), a1);
      m.send(d, a1);
      m.stop();
      chk_bit(a1, i[0]);
      cnt = (i == 0) ? cnt + 2 : cnt - 2;
      wb(0, OFS_CNT, 0, rd);
      chk(rd & 32'hff, 32'(cnt & 255));
      wb(0, OFS_DATA, 0, rd);
      chk(rd & 32'hff, {24'h0, d});
    end
    $display("done: data and count");
    for (int i = 0; i < 3; i++) begin
      own10 = 10'($urandom);
      ctrl = 32'h1 | (32'(i < 2) << B_TEN) | (32'(own10) << ADR_LO);
      wb(1, OFS_CTRL, ctrl, rd);
      m.start();
      m.send({TEN_HDR, own10[9:8], 1'b0}, a0);
      m.send(own10[7:0] ^ 8'(i), a1);
      m.stop();
      chk_bit(a0, i == 2);
      if (i < 2) chk_bit(a1, i[0]);
    end
    $display("done: ten-bit");
    for (int i = 0; i < 2; i++) begin
      ctrl = 32'h1 | (32'(own) << ADR_LO) | (32'h1 << (i ? B_STRETCH_ON_DATA_RECEIVE : B_STRETCH_ON_ADDRESS_MATCH));
      wb(1, OFS_CTRL, ctrl, rd);
      fork
        begin
          m.start();
          m.send({own, 1'b0}, a0);
          m.send(8'h5a, a1);
          m.stop();
        end
        begin
          rd = 0;
          k = 0;
          while (rd[S_STRETCH] !== 1'b1 && k < 2000) begin
            wb(0, OFS_STAT, 0, rd);
            k++;
          end
          repeat (240) @(posedge clk_i);
          chk_bit(m_scl & ~scl_w, 1'b1);
          wb(1, OFS_REL, 32'h1, rd);
        end
      join
      chk_bit(a1, 1'b0);
    end
    chk(32'(m.stalls), 32'h0);
    $display("done: stretch");
    // a correct pec leaves no error; a corrupted one sets the sticky flag
    for (int i = 0; i < 2; i++) begin
      ctrl = 32'h1 | (32'h1 << B_PACKET_CHECK_ENABLE) | (32'(own) << ADR_LO);
      wb(1, OFS_CTRL, ctrl, rd);
      d = 8'($urandom);
      pc = crc8(crc8(8'h00, {own, 1'b0}), d) ^ 8'(i);
      m.start();
      m.send({own, 1'b0}, a0);
      m.send(d, a1);
      m.send(pc, a1);
      m.stop();
      repeat (10) @(posedge clk_i);
      wb(0, OFS_STAT, 0, rd);
      chk_bit(rd[S_PECERR], i[0]);
      wb(1, OFS_STAT, 32'h1 << S_PECERR, rd);
    end
    $display("done: pec");
    give_verdict();
  end
endmodule : tb_two_wire_slave_control

// File: sim/tws_i2c_master.sv
/*
 * behavioural i2c bus master that drives the slave's bus pins.
 * assumes open-drain scl and sda wires pulled up in the bench.
 */
module tws_i2c_master (
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // bit and frame tasks
  int stalls = 0;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge link_clk_i);
  endtask : hold
  // a held clock is waited out; the bound makes a stuck slave visible
  task automatic bit_xfer(input logic b, output logic r);
    int k;
    sda_o <= b;
    hold(5);
    scl_o <= 1'b1;
    k = 0;
    while (scl_i !== 1'b1 && k < 3000) begin
      hold(1);
      k++;
    end
    if (k == 3000) stalls++;
    hold(4);
    r = sda_i;
    hold(2);
    scl_o <= 1'b0;
    hold(1);
  endtask : bit_xfer
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
    bit_xfer(1'b1, ack);
  endtask : send
  task automatic start();
    hold(5);
    sda_o <= 1'b0;
    hold(5);
    scl_o <= 1'b0;
    hold(2);
  endtask : start
  task automatic stop();
    sda_o <= 1'b0;
    hold(3);
    scl_o <= 1'b1;
    hold(5);
    sda_o <= 1'b1;
    hold(8);
  endtask : stop
endmodule : tws_i2c_master
